// >>> hdl/wave_shaping_cfg.svh
// Offsets, field positions, reset values and counts of the wave shaping lookup
`ifndef WAVE_SHAPING_CFG_SVH
`define WAVE_SHAPING_CFG_SVH

// Lookup table window, one aligned word per entry
`define LUT_BASE_ADDR    24'h201368
`define LUT_LAST_ADDR    24'h2013A7
`define LUT_ENTRIES      16
`define LUT_IDX_W        4
`define LUT_SIZE_ADDR    24'h2013A8
`define LUT_SIZE_RESET   5'h00

// Control: protocol index and load strobe
`define CTRL_ADDR        24'h2013AC
`define CTRL_PROTO_LSB   0
`define CTRL_PROTO_MSB   3
`define CTRL_LOAD_BIT    8
`define PROTO_RESET      4'h0
`define PROTO_COUNT      13

// Shaping value applied by a protocol load
`define BASE_ADDR        24'h2013B0
`define BASE_RESET       12'h000

// Status: applied shaping, latched gear, busy, match
`define STATUS_ADDR      24'h2013B4

// Entry layout
`define GEAR_MIN         4'h1
`define GEAR_MAX         4'hE
`define FIELD_W          4
`define ADDR_W           24

`endif

// >>> hdl/wave_shaping_pkg.sv
// Types shared by the wave shaping lookup block
package wave_shaping_pkg;

   // One lookup table word as stored, bit 31 at the top
   typedef struct packed {
      logic [2:0]  reserved;
      logic [12:0] proto_mask;
      logic [3:0]  residual;
      logic [3:0]  rising;
      logic [3:0]  falling;
      logic [3:0]  gear;
   } lut_entry_s;

   // Transmit shaping fields, residual on top
   typedef struct packed {
      logic [3:0] residual;
      logic [3:0] rising;
      logic [3:0] falling;
   } shape_s;

   typedef enum logic [1:0] {
      SCAN_IDLE,
      SCAN_WALK,
      SCAN_COMMIT
   } scan_state_e;

endpackage

// >>> hdl/shape_field_add.sv
// Saturating add of a sign and magnitude correction to one shaping field
`timescale 1ns/100ps
`include "wave_shaping_cfg.svh"

module shape_field_add (
   input  wire logic [`FIELD_W-1:0] value,
   input  wire logic [`FIELD_W-1:0] delta,
   output logic      [`FIELD_W-1:0] result
);

   logic [`FIELD_W:0] wide;

   // Top bit of delta is the sign, low three the magnitude
   always_comb begin
      wide = {1'b0, value};
      if (delta[`FIELD_W-1]) begin
         if (value < {1'b0, delta[`FIELD_W-2:0]}) begin
            result = '0; // Clamp instead of wrapping to a huge value
         end else begin
            result = value - {1'b0, delta[`FIELD_W-2:0]};
         end
      end else begin
         wide = {1'b0, value} + {2'b00, delta[`FIELD_W-2:0]};
         result = wide[`FIELD_W] ? '1 : wide[`FIELD_W-1:0];
      end
   end

endmodule

// >>> hdl/lut_entry_match.sv
// Decides whether one table word applies to the active protocol and gear
`timescale 1ns/100ps
`include "wave_shaping_cfg.svh"

module lut_entry_match (
   input  wire wave_shaping_pkg::lut_entry_s entry,
   input  wire logic [3:0]                   proto,
   input  wire logic [3:0]                   gear,
   output logic                              applies,
   output logic                              exact,
   output logic                              beyond
);

   logic usable;

   // Gear outside 1..14 or reserved bits set makes the word unusable
   always_comb begin
      usable = (entry.reserved == 3'h0) &&
               (entry.gear >= `GEAR_MIN) && (entry.gear <= `GEAR_MAX) &&
               (proto < 4'(`PROTO_COUNT)) && entry.proto_mask[proto];
      applies = usable && (entry.gear <= gear);
      exact   = usable && (entry.gear == gear);
      beyond  = (entry.gear > gear); // Ascending order lets the walk stop here
   end

endmodule

// >>> hdl/adaptive_shaping_control.sv
// Adaptive transmit wave shaping: table walk on gear switch or protocol load
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "wave_shaping_cfg.svh"

module adaptive_shaping_control (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic [`ADDR_W-1:0]    reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   input  wire logic [3:0]            power_control_gear,
   output wave_shaping_pkg::shape_s   transmit_shape,
   output logic                       scan_busy
);

   // ****************************************************************
   // Storage and control registers
   // ****************************************************************

   wave_shaping_pkg::lut_entry_s lut_r [`LUT_ENTRIES];
   logic [4:0]                   lut_size_r;
   logic [3:0]                   proto_r;
   wave_shaping_pkg::shape_s     base_r;
   wave_shaping_pkg::shape_s     shape_r;
   wave_shaping_pkg::shape_s     acc_r;
   wave_shaping_pkg::shape_s     acc_nxt;
   wave_shaping_pkg::scan_state_e state_r;
   logic [`LUT_IDX_W-1:0]        idx_r;
   logic [3:0]                   gear_seen_r;
   logic [3:0]                   gear_scan_r;
   logic                         matched_r;
   logic                         load_cmd;
   logic                         gear_switch;
   logic                         start_scan;
   logic                         applies;
   logic                         exact;
   logic                         beyond;
   logic                         last_idx;
   logic [31:0]                  rdata_r;
   logic                         busy_r;

   // Table word index when the address falls in the table window
   function automatic logic lut_hit(input logic [`ADDR_W-1:0] a);
      lut_hit = (a >= `LUT_BASE_ADDR) && (a <= `LUT_LAST_ADDR) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [`LUT_IDX_W-1:0] lut_index(input logic [`ADDR_W-1:0] a);
      logic [`ADDR_W-1:0] off;
      off = a - `LUT_BASE_ADDR;
      lut_index = off[`LUT_IDX_W+1:2];
   endfunction

   // ****************************************************************
   // Register writes
   // ****************************************************************

   // Table words; byte 0 of a word is its least significant byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `LUT_ENTRIES; i++) begin
            lut_r[i] <= '0;
         end
      end else if (reg_wr && lut_hit(reg_addr)) begin
         lut_r[lut_index(reg_addr)] <= reg_wdata;
      end
   end

   // Table size, clamped so the walk never leaves the table
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lut_size_r <= `LUT_SIZE_RESET;
      end else if (reg_wr && (reg_addr == `LUT_SIZE_ADDR)) begin
         if (reg_wdata[7:0] > 8'(`LUT_ENTRIES)) begin
            lut_size_r <= 5'(`LUT_ENTRIES);
         end else begin
            lut_size_r <= reg_wdata[4:0];
         end
      end
   end

   // Protocol selection and the base shaping value of a load
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         proto_r <= `PROTO_RESET;
         base_r  <= `BASE_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `CTRL_ADDR) begin
            proto_r <= reg_wdata[`CTRL_PROTO_MSB:`CTRL_PROTO_LSB];
         end else if (reg_addr == `BASE_ADDR) begin
            base_r <= reg_wdata[11:0];
         end
      end
   end

   // Load strobe is a write to control with the load bit set
   assign load_cmd = reg_wr && (reg_addr == `CTRL_ADDR) && reg_wdata[`CTRL_LOAD_BIT];

   // ****************************************************************
   // Gear tracking
   // ****************************************************************

   // Previous gear, compared each cycle to spot a switch
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gear_seen_r <= 4'h0;
      end else begin
         gear_seen_r <= power_control_gear;
      end
   end

   assign gear_switch = (power_control_gear != gear_seen_r);
   assign start_scan  = gear_switch || load_cmd;

   // ****************************************************************
   // Table walk
   // ****************************************************************

   lut_entry_match u_match (
      .entry   (lut_r[idx_r]),
      .proto   (proto_r),
      .gear    (gear_scan_r),
      .applies (applies),
      .exact   (exact),
      .beyond  (beyond)
   );

   // Per-field correction of the running sum, sign plus magnitude
   generate
      for (genvar f = 0; f < 3; f++) begin : g_field
         shape_field_add u_add (
            .value  (acc_r[f*`FIELD_W +: `FIELD_W]),
            .delta  (lut_r[idx_r][(f+1)*`FIELD_W +: `FIELD_W]),
            .result (acc_nxt[f*`FIELD_W +: `FIELD_W])
         );
      end
   endgenerate

   assign last_idx = ({1'b0, idx_r} + 5'h01) >= lut_size_r;

   // Walk state; a new trigger mid-walk restarts from the first word
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r     <= wave_shaping_pkg::SCAN_IDLE;
         idx_r       <= '0;
         gear_scan_r <= 4'h0;
      end else if (start_scan) begin
         idx_r       <= '0;
         gear_scan_r <= power_control_gear;
         if (lut_size_r == 5'h00) begin
            state_r <= wave_shaping_pkg::SCAN_COMMIT;
         end else begin
            state_r <= wave_shaping_pkg::SCAN_WALK;
         end
      end else begin
         case (state_r)
            wave_shaping_pkg::SCAN_WALK: begin
               // Ascending gears: nothing past a higher gear can apply
               if (beyond || last_idx) begin
                  state_r <= wave_shaping_pkg::SCAN_COMMIT;
               end else begin
                  idx_r <= idx_r + 1'b1;
               end
            end
            wave_shaping_pkg::SCAN_COMMIT: begin
               state_r <= wave_shaping_pkg::SCAN_IDLE;
            end
            default: begin
               state_r <= wave_shaping_pkg::SCAN_IDLE;
            end
         endcase
      end
   end

   // Running sum starts from the load value and gathers every gear up to and including the scanned one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_r     <= `BASE_RESET;
         matched_r <= 1'b0;
      end else if (start_scan) begin
         acc_r     <= base_r; // Load and gear switch both restart from the load value
         matched_r <= 1'b0;
      end else if ((state_r == wave_shaping_pkg::SCAN_WALK) && applies) begin
         acc_r <= acc_nxt;
         if (exact) begin
            matched_r <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Applied shaping and status
   // ****************************************************************

   // Load resets to the base value; a walk only commits on a real match
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shape_r <= `BASE_RESET;
      end else if (load_cmd) begin
         shape_r <= base_r;
      end else if ((state_r == wave_shaping_pkg::SCAN_COMMIT) && !start_scan) begin
         if (matched_r) begin
            shape_r <= acc_r;
         end // Otherwise left as it was
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= start_scan || ((state_r == wave_shaping_pkg::SCAN_WALK));
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************

   // Read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (!reg_rd) begin
         rdata_r <= 32'h0000_0000;
      end else if (lut_hit(reg_addr)) begin
         rdata_r <= lut_r[lut_index(reg_addr)];
      end else if (reg_addr == `LUT_SIZE_ADDR) begin
         rdata_r <= {27'h0, lut_size_r};
      end else if (reg_addr == `CTRL_ADDR) begin
         rdata_r <= {28'h0, proto_r};
      end else if (reg_addr == `BASE_ADDR) begin
         rdata_r <= {20'h0, base_r};
      end else if (reg_addr == `STATUS_ADDR) begin
         rdata_r <= {10'h0, matched_r, busy_r, 4'h0, gear_scan_r, shape_r};
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign reg_rdata      = rdata_r;
   assign transmit_shape = shape_r;
   assign scan_busy      = busy_r;

endmodule

// >>> verification/adaptive_shaping_chk.sv
// Port-level assertions for the adaptive shaping control block
`timescale 1ns/100ps
`include "wave_shaping_cfg.svh"

module adaptive_shaping_chk (
   input wire logic                     clock,
   input wire logic                     rst,
   input wire logic [`ADDR_W-1:0]       reg_addr,
   input wire logic [31:0]              reg_wdata,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [31:0]              reg_rdata,
   input wire logic [3:0]               power_control_gear,
   input wire wave_shaping_pkg::shape_s transmit_shape,
   input wire logic                     scan_busy
);
   logic        load;
   logic [11:0] base_r;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Load command, which also forces the base value
   assign load = reg_wr && reg_addr == `CTRL_ADDR && reg_wdata[`CTRL_LOAD_BIT];
   // Shadow of the base shaping register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         base_r <= `BASE_RESET;
      end else if (reg_wr && reg_addr == `BASE_ADDR) begin
         base_r <= reg_wdata[11:0];
      end
   end
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_unmapped_read: assert property (
      reg_rd && reg_addr > `STATUS_ADDR |=> reg_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_base_readback: assert property (
      reg_rd && reg_addr == `BASE_ADDR |=> reg_rdata == {20'h0, base_r})
      else $error("base readback wrong");
   a_gear_walk: assert property (
      power_control_gear != $past(power_control_gear) |=> scan_busy)
      else $error("gear switch did not start a walk");
   a_load_walk: assert property (load |=> scan_busy)
      else $error("load did not start a walk");
   a_load_base: assert property (load |=> transmit_shape == base_r)
      else $error("load did not apply base value");
   a_walk_bound: assert property ($rose(scan_busy) |-> ##[1:17] !scan_busy)
      else $error("walk ran too long");
   // Busy lags the walk by one edge, so the commit edge is the last busy sample
   a_shape_hold: assert property (
      scan_busy && !load ##1 scan_busy |-> $stable(transmit_shape))
      else $error("shape moved during walk");
   a_shape_cause: assert property (
      $changed(transmit_shape) |-> $past(load) || $past(scan_busy, 2))
      else $error("shape moved without load or walk");
   a_status_shape: assert property (
      reg_rd && reg_addr == `STATUS_ADDR |=> reg_rdata[11:0] == $past(transmit_shape))
      else $error("status shape differs from output");
   // Main scenarios reached
   cover property (load ##1 scan_busy);
   cover property ($fell(scan_busy) && $changed(transmit_shape));
   cover property (reg_rd && reg_addr == `STATUS_ADDR);
endmodule

bind adaptive_shaping_control adaptive_shaping_chk chk_u (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .power_control_gear(power_control_gear), .transmit_shape(transmit_shape),
   .scan_busy(scan_busy));

// >>> verification/gear_loop_model.sv
// Behavioural power control gear loop that settles onto a target gear
`timescale 1ns/100ps

module gear_loop_model #(
   parameter int SETTLE = 3
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [3:0] target,
   output logic      [3:0] gear
);
   int unsigned wait_r;
   // Gear jumps only after the target differed from it for SETTLE+1 edges, so no stray middle gears
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_r <= 0;
         gear   <= 4'h0;
      end else if (target == gear) begin
         wait_r <= 0;
      end else if (wait_r == SETTLE) begin
         gear   <= target;
         wait_r <= 0;
      end else begin
         wait_r <= wait_r + 1;
      end
   end
endmodule

// >>> verification/adaptive_shaping_control_tb_top.sv
// Self-checking bench for the adaptive shaping control block
`timescale 1ns/100ps
`include "wave_shaping_cfg.svh"

module adaptive_shaping_control_tb_top;
   logic                         clock;
   logic                         rst;
   logic [`ADDR_W-1:0]           reg_addr;
   logic [31:0]                  reg_wdata;
   logic                         reg_wr;
   logic                         reg_rd;
   logic [31:0]                  reg_rdata;
   logic [3:0]                   target;
   logic [3:0]                   power_control_gear;
   wave_shaping_pkg::shape_s     transmit_shape;
   logic                         scan_busy;
   wave_shaping_pkg::lut_entry_s tbl [7];
   wave_shaping_pkg::shape_s     exp_s;
   wave_shaping_pkg::shape_s     last_s;
   logic [11:0]                  base;
   logic [31:0]                  rd_v;
   logic [7:0]                   seed;
   logic [3:0]                   gp;
   int                           failures;
   int                           checked;
   logic [`ADDR_W-1:0]           reset_addr [5] = '{`LUT_BASE_ADDR, `LUT_SIZE_ADDR,
                                    `BASE_ADDR, `STATUS_ADDR, 24'h2013B8};

   adaptive_shaping_control dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .power_control_gear(power_control_gear), .transmit_shape(transmit_shape),
      .scan_busy(scan_busy));
   gear_loop_model gear_u (.clock(clock), .rst(rst), .target(target),
      .gear(power_control_gear));

   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Maximal 8-bit LFSR step, never reaches zero
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // One field plus a sign and magnitude correction, clamped
   function automatic logic [3:0] sat(input logic [3:0] v, input logic [3:0] d);
      int r;
      r = d[3] ? int'(v) - int'(d[2:0]) : int'(v) + int'(d[2:0]);
      return (r < 0) ? 4'h0 : (r > 15) ? 4'hF : 4'(r);
   endfunction

   // Sum of all usable entries up to gear g; kept only on an exact gear hit
   function automatic wave_shaping_pkg::shape_s expect_shape(input logic [3:0] g,
      input logic [3:0] p, input bit load, input wave_shaping_pkg::shape_s prev);
      wave_shaping_pkg::shape_s acc;
      bit                       hit;
      acc = base;
      hit = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (tbl[i].reserved == 3'h0 && tbl[i].proto_mask[p] && tbl[i].gear <= g) begin
            acc.residual = sat(acc.residual, tbl[i].residual);
            acc.rising   = sat(acc.rising, tbl[i].rising);
            acc.falling  = sat(acc.falling, tbl[i].falling);
            hit          = hit | (tbl[i].gear == g);
         end
      end
      return hit ? acc : (load ? base : prev);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("Checks made %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Register port cycles, driven just after a rising edge
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      @(posedge clock); // Gap edge, so a following write never re-drives the strobe at once
   endtask

   task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
      @(posedge clock);
   endtask

   // Busy must rise and fall within a bound; the commit lands on the edge where busy falls
   task automatic wait_walk();
      int n;
      bit seen;
      n    = 0;
      seen = 1'b0;
      while (!(seen && scan_busy === 1'b0) && n < 60) begin
         @(posedge clock);
         #1;
         seen = seen | (scan_busy === 1'b1);
         n++;
      end
      if (!(seen && scan_busy === 1'b0)) begin
         check("walk completion", 32'h0, 32'h1);
         give_verdict();
      end
      repeat (2) @(posedge clock);
   endtask

   task automatic step(input logic [3:0] g, input logic [3:0] p);
      target <= g;
      exp_s = expect_shape(g, p, 1'b0, last_s);
      wait_walk();
      check("gear switch", {20'h0, transmit_shape}, {20'h0, exp_s});
      last_s = exp_s;
   endtask

   initial begin
      rst       = 1'b1;
      reg_addr  = '0;
      reg_wdata = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      target    = 4'h0;
      failures  = 0;
      checked   = 0;
      seed      = 8'h3F;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      // Reset values, one unmapped place among them
      check("shape at reset", {20'h0, transmit_shape}, 32'h0);
      foreach (reset_addr[i]) begin
         rd(reset_addr[i], rd_v);
         check("reset read", rd_v, 32'h0);
      end
      $display("reset test done");
      // Random table, gears ascending; the last word has a reserved bit set
      for (int i = 0; i < 7; i++) begin
         seed = lfsr(seed);
         tbl[i].proto_mask[7:0] = seed;
         seed = lfsr(seed);
         tbl[i].proto_mask[12:8] = seed[4:0];
         tbl[i].residual = {seed[7], 2'b00, seed[5]};
         tbl[i].rising   = {seed[6], 2'b00, seed[7]};
         tbl[i].falling  = {seed[5], 2'b00, seed[6]};
         tbl[i].gear     = 4'(i + 1);
         tbl[i].reserved = (i == 6) ? 3'h1 : 3'h0;
         wr(`LUT_BASE_ADDR + 24'(4 * i), tbl[i]);
      end
      rd(`LUT_BASE_ADDR + 24'h00000C, rd_v);
      check("table word 3", rd_v, tbl[3]);
      // Oversized table length must clamp to the table depth
      wr(`LUT_SIZE_ADDR, 32'h20);
      rd(`LUT_SIZE_ADDR, rd_v);
      check("size clamp", rd_v, 32'h10);
      wr(`LUT_SIZE_ADDR, 32'h7);
      base = 12'h798;
      wr(`BASE_ADDR, {20'h0, base});
      last_s = '0;
      $display("table test done");
      // Every protocol: random gear, load, sweep up to the top then back to gear 0
      for (int p = 0; p < `PROTO_COUNT; p++) begin
         seed = lfsr(seed);
         gp   = 4'(1 + seed % 6);
         // Until the load below, the protocol of the previous round is active
         step(gp, 4'((p == 0) ? 0 : p - 1));
         wr(`CTRL_ADDR, 32'h100 | 32'(p));
         exp_s = expect_shape(gp, 4'(p), 1'b1, last_s);
         wait_walk();
         check("load shape", {20'h0, transmit_shape}, {20'h0, exp_s});
         last_s = exp_s;
         rd(`STATUS_ADDR, rd_v);
         check("status", rd_v & 32'h0010FFFF, {16'h0, gp, exp_s});
         for (int g = gp + 1; g <= 8; g++) begin
            step(4'(g % 8), 4'(p));
         end
         $display("protocol %0d done", p);
      end
      give_verdict();
   end
endmodule
